// File: pkg/fls_pkg.sv
// Constants, channel tables and carrier types of the fault latch sequencer.
// Assumes a single 250 MHz clock and comparator flags synchronous to it.
package fls_pkg;

	// Clock and qualification times
	localparam int CLK_NS      = 4;
	localparam int T_1MS_NS    = 1_000_000;
	localparam int T_128US_NS  = 128_000;
	localparam int T_2S1_MS    = 2100;
	localparam int T_TSD_NS    = 30_000;
	localparam int CYC_1MS     = (T_1MS_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_128US   = (T_128US_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_2S1     = T_2S1_MS * (1_000_000 / CLK_NS);
	localparam int CYC_TSD     = (T_TSD_NS + CLK_NS - 1) / CLK_NS;

	// Widths
	localparam int TICK_W      = 30;
	localparam int TSD_W       = 16;
	localparam int QCNT_W      = 3;
	localparam int HC_W        = 3;
	localparam int NCH         = 11;
	localparam int NTICK       = 3;
	localparam int NEV         = 2;

	// Timer selectors
	localparam int TK_1MS      = 0;
	localparam int TK_128US    = 1;
	localparam int TK_2S1      = 2;

	// Qualification channels
	localparam int CH_RES_STOP = 0;
	localparam int CH_EXT_ERR  = 1;
	localparam int CH_BACKUP   = 2;
	localparam int CH_OC       = 3;
	localparam int CH_DPL      = 4;
	localparam int CH_NOOP     = 5;
	localparam int CH_MZC      = 6;
	localparam int CH_SZC      = 7;
	localparam int CH_SOFT     = 8;
	localparam int CH_CUR      = 9;
	localparam int CH_OTHER    = 10;

	// Per-channel timer, terminal count, reset style and latch role
	localparam logic [NCH-1:0][1:0] CH_TICK = {
		2'h2, 2'h2, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h1, 2'h0};
	localparam logic [NCH-1:0][QCNT_W-1:0] CH_TERM = {
		3'h3, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h3, 3'h5, 3'h5};
	localparam logic [NCH-1:0] CH_CONT    = 11'h7E7;
	localparam logic [NCH-1:0] CH_LATCH   = 11'h7FE;
	localparam logic [NCH-1:0] CH_ZC_MASK = 11'h0C0;

	// Overcurrent detections per half cycle that make one fault event
	localparam logic [HC_W-1:0] HC_EVENTS = 3'h4;

	typedef struct packed {
		logic out_sense_le_stop_thr;
		logic stop_thr_ge_4v0;
		logic backup_ov_gt_2v922;
		logic out_sense_gt_2v922;
		logic out_sense_gt_2v700;
		logic out_sense_gt_2v4;
		logic out_sense_lt_2v4;
		logic out_sense_le_0v3;
		logic corr_oc_pulse;
		logic dyn_limit_pulse;
		logic half_cycle_end;
		logic ac_detect_on;
		logic c_period;
		logic master_zc_lost;
		logic slave_zc_lost;
		logic mains_rms_ge_7v0;
		logic err_amp_le_0v4;
		logic err_amp_overcurrent;
		logic zc_clamp_overcurrent;
		logic cur_pos_gt_0v22;
		logic cur_neg_lt_m0v25;
		logic cur_gt_0v175;
		logic softstart_gt_4v0;
		logic ref_overvolt;
		logic minfreq_low_current;
		logic over_temp;
		logic supply_undervolt;
		logic standby_mode;
		logic drive_high_req;
		logic drive_low_req;
	} fls_sense_t;

	typedef struct packed {
		logic shutdown_latch;
		logic thermal_latch;
		logic converter_halt;
		logic res_stop;
		logic res_drive_high;
		logic res_drive_low;
		logic corr_drive_stop;
		logic softstart_charge;
		logic power_good;
		logic reference_on;
		logic mains_detect_on;
	} fls_out_t;

	typedef struct packed {
		logic [NTICK-1:0][TICK_W-1:0] tick_cnt;
		logic [TSD_W-1:0]             tsd_cnt;
		logic [NCH-1:0][QCNT_W-1:0]   qcnt;
		logic [NEV-1:0][HC_W-1:0]     hc_cnt;
		logic [NEV-1:0]               seen;
		logic                         standby_d;
		logic                         shutdown;
		logic                         thermal;
		fls_out_t                     out;
	} fls_state_t;

endpackage

// File: test/fls_fault_latch_sequencer_properties.sv
// Port checker for the fault latch sequencer.
// Assumes one clock and bind to the top module.
`timescale 1ns/100ps
`default_nettype none
module fls_fault_latch_sequencer_properties
	import fls_pkg::*;
(
	input  wire logic       i_ref_clk,
	input  wire logic       i_reset_n,
	input  wire fls_sense_t i_sense,
	input  wire fls_out_t   o_ctrl
);
	fls_sense_t s;
	fls_out_t   o;
	logic [1:0] up_ff;
	assign s = i_sense;
	assign o = o_ctrl;
	always_ff @(posedge i_ref_clk)
	begin
		up_ff <= i_reset_n ? {up_ff[0], 1'h1} : 2'h0;
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_sb_quiet;
		$stable(s.standby_mode) [*3];
	endsequence
	sequence s_uv_quiet;
		!s.supply_undervolt [*2];
	endsequence
	property p_drv;
		o.shutdown_latch |-> !o.res_drive_high && !o.res_drive_low;
	endproperty
	a_drv: assert property (p_drv) else $error("drive during latch");
	property p_sd_out;
		o.shutdown_latch && !o.thermal_latch |-> o.reference_on && o.mains_detect_on
			&& !o.power_good && o.converter_halt;
	endproperty
	a_sd_out: assert property (p_sd_out) else $error("latch outputs");
	property p_th_out;
		o.thermal_latch |-> !o.reference_on && o.converter_halt;
	endproperty
	a_th_out: assert property (p_th_out) else $error("thermal outputs");
	property p_sd_hold;
		s_sb_quiet ##0 o.shutdown_latch |=> o.shutdown_latch;
	endproperty
	a_sd_hold: assert property (p_sd_hold) else $error("latch lost");
	property p_th_hold;
		s_uv_quiet ##0 o.thermal_latch |=> o.thermal_latch;
	endproperty
	a_th_hold: assert property (p_th_hold) else $error("thermal lost");
	property p_corr;
		up_ff[1] && s.out_sense_gt_2v700 |=> o.corr_drive_stop;
	endproperty
	a_corr: assert property (p_corr) else $error("corr drive");
	property p_ss;
		up_ff[1] && (s.cur_pos_gt_0v22 || s.cur_neg_lt_m0v25) |=> o.softstart_charge;
	endproperty
	a_ss: assert property (p_ss) else $error("soft start");
	property p_th_dly;
		$rose(o.thermal_latch) |-> $past(s.over_temp, 2) && $past(s.over_temp, 3);
	endproperty
	a_th_dly: assert property (p_th_dly) else $error("thermal early");
	property p_stop;
		!s.out_sense_le_stop_thr [*3] ##0 !o.converter_halt |-> !o.res_stop;
	endproperty
	a_stop: assert property (p_stop) else $error("stop stuck");
endmodule
bind fls_fault_latch_sequencer fls_fault_latch_sequencer_properties u_props (
	.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_sense(i_sense), .o_ctrl(o_ctrl));
`default_nettype wire

// File: test/fls_fault_latch_sequencer_tb_top.sv
// Self-checking bench of the fault latch sequencer.
// Assumes shortened timer counts and the sense model in front.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
	$display("[FAIL] %s exp %h got %h", n, e, a); end end
`define M(f) fls_sense_t'{f: 1'h1, default: 1'h0}
module fls_fault_latch_sequencer_tb_top
	import fls_pkg::*;
;
	logic       clk = 1'h0;
	logic       rst_n = 1'h0;
	logic [2:0] pulses = 3'h0;
	fls_sense_t lvl = '0;
	fls_sense_t sns;
	fls_out_t   o;
	int         n_errors = 0;
	int         comparisons = 0;
	always #2 clk = ~clk;
	fls_sense_model model_u (.i_ref_clk(clk), .i_reset_n(rst_n), .i_lvl(lvl),
		.i_pulses(pulses), .o_sense(sns));
	fls_fault_latch_sequencer #(.P_CYC_1MS(4), .P_CYC_128US(3), .P_CYC_2S1(12),
		.P_CYC_TSD(3)) dut_u (.i_ref_clk(clk), .i_reset_n(rst_n), .i_sense(sns), .o_ctrl(o));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic restart();
		@(posedge clk);
		rst_n <= 1'h0;
		lvl <= `M(drive_high_req) | `M(drive_low_req) | `M(out_sense_gt_2v4);
		pulses <= 3'h0;
		cyc(8);
		@(posedge clk);
		rst_n <= 1'h1;
		cyc(3);
	endtask
	task automatic t_latch(input fls_sense_t m, input logic [2:0] p, input int e,
		input int l, input logic v);
		restart();
		@(posedge clk);
		pulses <= p;
		lvl <= lvl | m;
		cyc(e);
		`CHK("early", 1'h0, o.shutdown_latch)
		`CHK("drive", 1'h1, o.res_drive_high)
		`CHK("drive_lo", 1'h1, o.res_drive_low)
		`CHK("pgood", 1'h1, o.power_good)
		`CHK("ss", m.cur_pos_gt_0v22 | m.cur_neg_lt_m0v25, o.softstart_charge)
		cyc(l - e);
		`CHK("latch", v, o.shutdown_latch)
		`CHK("halt", v, o.converter_halt)
		`CHK("drive_off", !v, o.res_drive_high)
		`CHK("drive_lo_off", !v, o.res_drive_low)
		`CHK("pgood_off", !v, o.power_good)
		`CHK("corr_stop", v | m.out_sense_gt_2v700, o.corr_drive_stop)
		`CHK("ref_on", 1'h1, o.reference_on)
		`CHK("mains_on", 1'h1, o.mains_detect_on)
		// Fault gone first, else a count at terminal re-sets the latch
		@(posedge clk);
		lvl <= (lvl & ~m) | (m & `M(c_period));
		cyc(30);
		`CHK("sticky", v, o.shutdown_latch)
		@(posedge clk);
		lvl <= lvl | `M(standby_mode);
		cyc(6);
		`CHK("standby", 1'h0, o.shutdown_latch)
		`CHK("pgood_back", 1'h1, o.power_good)
	endtask
	task automatic t_stop();
		restart();
		@(posedge clk);
		lvl.out_sense_le_stop_thr <= 1'h1;
		cyc(15);
		`CHK("stop_early", 1'h0, o.res_stop)
		cyc(11);
		`CHK("stop_on", 1'h1, o.res_stop)
		`CHK("stop_drv", 1'h0, o.res_drive_high)
		`CHK("stop_nolatch", 1'h0, o.shutdown_latch)
		@(posedge clk);
		lvl.out_sense_le_stop_thr <= 1'h0;
		cyc(4);
		`CHK("stop_off", 1'h0, o.res_stop)
	endtask
	task automatic t_tsd();
		restart();
		@(posedge clk);
		lvl.over_temp <= 1'h1;
		cyc(2);
		`CHK("th_early", 1'h0, o.thermal_latch)
		cyc(10);
		`CHK("th_set", 1'h1, o.thermal_latch)
		`CHK("th_ref", 1'h0, o.reference_on)
		`CHK("th_sep", 1'h0, o.shutdown_latch)
		@(posedge clk);
		lvl <= `M(standby_mode);
		cyc(5);
		`CHK("th_hold", 1'h1, o.thermal_latch)
		@(posedge clk);
		lvl.supply_undervolt <= 1'h1;
		cyc(4);
		`CHK("th_clr", 1'h0, o.thermal_latch)
	endtask
	task automatic finish_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
		begin
			$display("Simulation passed");
		end
		else
		begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial
	begin
		#(20000 * 4);
		n_errors++;
		finish_test();
	end
	initial
	begin
		t_latch(`M(backup_ov_gt_2v922) | `M(out_sense_gt_2v922), 3'h0, 7, 20, 1'h0);
		t_latch(`M(backup_ov_gt_2v922), 3'h0, 7, 20, 1'h1);
		t_latch(`M(stop_thr_ge_4v0) | `M(out_sense_gt_2v700), 3'h0, 11, 20, 1'h1);
		t_latch(`M(softstart_gt_4v0) | `M(cur_pos_gt_0v22), 3'h0, 11, 20, 1'h1);
		t_latch(`M(corr_oc_pulse) | `M(ac_detect_on), 3'h4, 40, 100, 1'h1);
		t_latch(`M(corr_oc_pulse) | `M(ac_detect_on), 3'h3, 40, 100, 1'h0);
		t_latch(`M(dyn_limit_pulse) | `M(ac_detect_on), 3'h4, 40, 100, 1'h1);
		t_latch(`M(out_sense_lt_2v4), 3'h0, 40, 70, 1'h1);
		t_latch(`M(master_zc_lost) | `M(c_period), 3'h0, 40, 70, 1'h1);
		t_latch(`M(slave_zc_lost) | `M(c_period), 3'h0, 40, 70, 1'h1);
		t_latch(`M(master_zc_lost), 3'h0, 40, 70, 1'h0);
		t_latch(`M(slave_zc_lost) | `M(c_period) | `M(mains_rms_ge_7v0)
			| `M(err_amp_le_0v4), 3'h0, 40, 70, 1'h0);
		t_latch(`M(cur_gt_0v175), 3'h0, 40, 70, 1'h1);
		t_latch(`M(ref_overvolt), 3'h0, 20, 45, 1'h1);
		t_latch(`M(zc_clamp_overcurrent), 3'h0, 20, 45, 1'h1);
		t_stop();
		t_tsd();
		finish_test();
	end
endmodule
`default_nettype wire

// File: test/fls_sense_model.sv
// Comparator and mains timing model in front of the sequencer.
// Levels come from the bench; pulses repeat each 6-cycle half cycle.
`timescale 1ns/100ps
`default_nettype none
module fls_sense_model
	import fls_pkg::*;
(
	input  wire logic       i_ref_clk,
	input  wire logic       i_reset_n,
	input  wire fls_sense_t i_lvl,
	input  wire logic [2:0] i_pulses,
	output var fls_sense_t  o_sense
);
	logic [2:0] ph_ff;
	always_ff @(posedge i_ref_clk)
	begin
		ph_ff <= (!i_reset_n || ph_ff == 3'h5) ? 3'h0 : ph_ff + 3'h1;
		o_sense <= i_lvl;
		o_sense.half_cycle_end <= ph_ff == 3'h5;
		o_sense.corr_oc_pulse <= i_lvl.corr_oc_pulse && ph_ff < i_pulses;
		o_sense.dyn_limit_pulse <= i_lvl.dyn_limit_pulse && ph_ff < i_pulses;
	end
endmodule
`default_nettype wire

// File: verilog/fls_fault_latch_sequencer.sv
// Fault qualification and shutdown latch logic of the converter controller.
// Assumes comparator and timer flags arrive synchronous to i_ref_clk.
`timescale 1ns/100ps
`default_nettype none

module fls_fault_latch_sequencer
	import fls_pkg::*;
#(
	parameter int P_CYC_1MS   = CYC_1MS,
	parameter int P_CYC_128US = CYC_128US,
	parameter int P_CYC_2S1   = CYC_2S1,
	parameter int P_CYC_TSD   = CYC_TSD
)
(
	input  wire logic       i_ref_clk,
	input  wire logic       i_reset_n,
	input  wire fls_sense_t i_sense,
	output fls_out_t        o_ctrl
);

	localparam logic [NTICK-1:0][TICK_W-1:0] PERIOD_M1 = {
		TICK_W'(P_CYC_2S1 - 1),
		TICK_W'(P_CYC_128US - 1),
		TICK_W'(P_CYC_1MS - 1)
	};
	localparam logic [TSD_W-1:0] TSD_TERM = TSD_W'(P_CYC_TSD);

	if (P_CYC_1MS < 2 || P_CYC_128US < 2 || P_CYC_2S1 < 2
		|| P_CYC_2S1 >= (1 << TICK_W) || P_CYC_1MS >= (1 << TICK_W)
		|| P_CYC_128US >= (1 << TICK_W)) begin : g_bad_tick
		$error("Timer period out of range");
	end
	if (P_CYC_TSD < 1 || P_CYC_TSD >= (1 << TSD_W)) begin : g_bad_tsd
		$error("Thermal delay out of range");
	end

	fls_state_t st_ff;
	fls_state_t nxt_st;

	logic [NTICK-1:0]             tick;
	logic [NTICK-1:0][TICK_W-1:0] nxt_tick_cnt;
	logic [NCH-1:0]               ch_cond;
	logic [NCH-1:0]               ch_valid;
	logic [NCH-1:0]               ch_clr;
	logic [NCH-1:0]               ch_done;
	logic [NCH-1:0][QCNT_W-1:0]   nxt_qcnt;
	logic [NEV-1:0][HC_W-1:0]     nxt_hc_cnt;
	logic [NEV-1:0]               nxt_seen;
	logic [NEV-1:0]               ev_pulse;
	logic                         zc_suppress;
	logic                         other_fault;
	logic                         tsd_fire;
	logic                         standby_entry;
	logic                         shutdown_set;
	logic                         halt;

	// Qualification timers
	for (genvar k = 0; k < NTICK; k++) begin : g_tick
		assign tick[k] = (st_ff.tick_cnt[k] == PERIOD_M1[k]);
		assign nxt_tick_cnt[k] = tick[k] ? '0 : TICK_W'(st_ff.tick_cnt[k] + 1'h1);
	end

	// Half-cycle event counting
	assign ev_pulse[0] = i_sense.corr_oc_pulse;
	assign ev_pulse[1] = i_sense.dyn_limit_pulse;

	for (genvar e = 0; e < NEV; e++) begin : g_ev
		logic [HC_W-1:0] hc_nxt;
		logic            seen_set;

		always_comb
		begin
			hc_nxt = st_ff.hc_cnt[e];
			seen_set = 1'h0;
			if (i_sense.half_cycle_end)
			begin
				seen_set = i_sense.ac_detect_on && (st_ff.hc_cnt[e] >= HC_EVENTS);
				hc_nxt = '0;
			end
			else if (i_sense.ac_detect_on && ev_pulse[e] && (st_ff.hc_cnt[e] < HC_EVENTS))
			begin
				hc_nxt = HC_W'(st_ff.hc_cnt[e] + 1'h1);
			end
		end

		assign nxt_hc_cnt[e] = hc_nxt;
		assign nxt_seen[e] = seen_set | (st_ff.seen[e] & ~tick[TK_2S1]);
	end

	// Channel conditions
	// Output at or below threshold
	assign ch_cond[CH_RES_STOP] = i_sense.out_sense_le_stop_thr;
	assign ch_cond[CH_EXT_ERR] = i_sense.stop_thr_ge_4v0;
	assign ch_cond[CH_BACKUP] = i_sense.backup_ov_gt_2v922 & ~i_sense.out_sense_gt_2v922;
	assign ch_cond[CH_OC] = st_ff.seen[0];
	assign ch_cond[CH_DPL] = st_ff.seen[1];
	assign ch_cond[CH_NOOP] = i_sense.out_sense_lt_2v4;
	assign ch_cond[CH_MZC] = i_sense.master_zc_lost;
	assign ch_cond[CH_SZC] = i_sense.slave_zc_lost;
	assign ch_cond[CH_SOFT] = i_sense.softstart_gt_4v0;
	assign ch_cond[CH_CUR] = i_sense.cur_gt_0v175;
	assign ch_cond[CH_OTHER] = other_fault;

	assign other_fault = i_sense.ref_overvolt
		| i_sense.err_amp_overcurrent
		| i_sense.zc_clamp_overcurrent
		| i_sense.out_sense_le_0v3
		| i_sense.minfreq_low_current;

	assign ch_valid = ~(CH_ZC_MASK & {NCH{~i_sense.c_period}});
	assign zc_suppress = i_sense.mains_rms_ge_7v0 & i_sense.err_amp_le_0v4;
	assign ch_clr = CH_ZC_MASK & {NCH{zc_suppress}};

	// Qualification counters
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		logic              ch_tick;
		logic [QCNT_W-1:0] q_nxt;

		assign ch_tick = tick[CH_TICK[g]];
		assign ch_done[g] = (st_ff.qcnt[g] == CH_TERM[g]);

		always_comb
		begin
			q_nxt = st_ff.qcnt[g];
			if (ch_clr[g])
			begin
				q_nxt = '0;
			end
			else if (!ch_valid[g])
			begin
				q_nxt = st_ff.qcnt[g];
			end
			else if (ch_tick && ch_cond[g])
			begin
				if (!ch_done[g])
				begin
					q_nxt = QCNT_W'(st_ff.qcnt[g] + 1'h1);
				end
			end
			else if (!ch_cond[g] && (ch_tick || CH_CONT[g]))
			begin
				q_nxt = '0;
			end
		end

		assign nxt_qcnt[g] = q_nxt;
	end

	assign tsd_fire = i_sense.over_temp && (st_ff.tsd_cnt >= TSD_TERM);

	assign standby_entry = i_sense.standby_mode & ~st_ff.standby_d;

	assign shutdown_set = |(ch_done & CH_LATCH & ~ch_clr);

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.tick_cnt = nxt_tick_cnt;
		nxt_st.qcnt = nxt_qcnt;
		nxt_st.hc_cnt = nxt_hc_cnt;
		nxt_st.seen = nxt_seen;
		nxt_st.standby_d = i_sense.standby_mode;

		if (!i_sense.over_temp)
		begin
			nxt_st.tsd_cnt = '0;
		end
		else if (st_ff.tsd_cnt < TSD_TERM)
		begin
			nxt_st.tsd_cnt = TSD_W'(st_ff.tsd_cnt + 1'h1);
		end

		nxt_st.shutdown = shutdown_set | (st_ff.shutdown & ~standby_entry);
		nxt_st.thermal = tsd_fire | (st_ff.thermal & ~i_sense.supply_undervolt);

		halt = nxt_st.shutdown | nxt_st.thermal;

		nxt_st.out.shutdown_latch = nxt_st.shutdown;
		nxt_st.out.thermal_latch = nxt_st.thermal;
		nxt_st.out.converter_halt = halt;
		nxt_st.out.res_stop = ch_done[CH_RES_STOP] | halt;
		nxt_st.out.res_drive_high = i_sense.drive_high_req & ~nxt_st.out.res_stop;
		nxt_st.out.res_drive_low = i_sense.drive_low_req & ~nxt_st.out.res_stop;
		nxt_st.out.corr_drive_stop = i_sense.out_sense_gt_2v700 | halt;
		nxt_st.out.softstart_charge = i_sense.cur_pos_gt_0v22 | i_sense.cur_neg_lt_m0v25;
		nxt_st.out.power_good = i_sense.out_sense_gt_2v4 & ~halt;
		nxt_st.out.reference_on = ~nxt_st.thermal;
		nxt_st.out.mains_detect_on = ~nxt_st.thermal;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_reset_n)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign o_ctrl = st_ff.out;

endmodule

`default_nettype wire
